// ==== nvs_sequencer.sv ====
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Memory select picks flash or data
// - Config select overrides memory select
// - Erase bit erases row, self-clears
// - Erase clear means write only
// - Reset during write sets error
// - Error keeps select bits intact
// - No permit, no erase or write
// - Self-timed; start bit clears when done
// - Writing zero to start does nothing
// - Read start: one cycle, self-clears
// - Eight-byte holding register feeds program
// - Bit 5 zero; control reset values
// - No read start with flash selected
module nvs_sequencer
#(
  parameter int WriteCycles = nvs_pkg::WRITE_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        masterClearReset,
  input  wire logic        watchdogTimeout,
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata,
  input  wire logic [7:0]  nvmReadData,
  output logic             nvmReadStb,
  output logic             nvmOpStb,
  output nvs_pkg::nvs_op_t nvmOp,
  output logic      [63:0] nvmProgData,
  output logic             coreStall,
  output logic             busy
);

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_BUSY  = 3'b010,
    ST_DONE  = 3'b100
  } nvs_state_t;

  nvs_state_t        state_q,    state_d;
  nvs_pkg::nvs_ctrl_t ctrl_q,    ctrl_d;
  logic [21:0]       table_pointer_q,   table_pointer_d;
  logic [7:0]        latch_q,    latch_d;
  logic [7:0]        rdBuf_q,    rdBuf_d;
  logic [7:0]        rdata_q,    rdata_d;
  logic [12:0]       count_q,    count_d;
  nvs_pkg::nvs_op_t  op_q,       op_d;
  logic              opStb_q,    opStb_d;
  logic              rdStb_q,    rdStb_d;
  logic              stall_q,    stall_d;
  logic              busy_q,     busy_d;
  logic              rdPend_q,   rdPend_d;
  logic              armed;
  logic              ctrlWrite;
  logic              unlockWrite;
  logic              tblWrite;
  logic              launch;
  logic              abortReset;
  logic [63:0]       holdData;

  assign ctrlWrite   = regWrite && regAddr == nvs_pkg::ADDR_CONTROL;
  assign unlockWrite = regWrite && regAddr == nvs_pkg::ADDR_UNLOCK;
  assign tblWrite    = regWrite && regAddr == nvs_pkg::ADDR_TBLWR;
  assign abortReset  = masterClearReset || watchdogTimeout;

  // ==========================================================
  // Helpers
  // ==========================================================
  nvs_unlock nvs_unlock_i
  (
    .clk         (clk),
    .srst        (srst),
    .anyWrite    (regWrite),
    .unlockWrite (unlockWrite),
    .wdata       (regWdata),
    .armed       (armed)
  );

  nvs_holding_reg nvs_holding_reg_i
  (
    .clk      (clk),
    .srst     (srst),
    .load     (tblWrite),
    .index    (table_pointer_q[2:0]),
    .dataIn   (latch_q),
    .holdData (holdData)
  );

  assign launch = ctrlWrite && regWdata[nvs_pkg::BIT_WR] && armed &&
                  ctrl_q.permit && state_q == ST_IDLE && !abortReset;

  // ==========================================================
  // Control and sequencing
  // ==========================================================
  always_comb
  begin
    state_d  = state_q;
    ctrl_d   = ctrl_q;
    count_d  = count_q;
    op_d     = op_q;
    opStb_d  = 1'b0;
    rdStb_d  = 1'b0;
    stall_d  = stall_q;
    busy_d   = busy_q;

    if (ctrlWrite)
    begin
      if (state_q == ST_IDLE)
      begin
        ctrl_d.memSel = regWdata[nvs_pkg::BIT_MEM];
        ctrl_d.cfgSel = regWdata[nvs_pkg::BIT_CFG];
        ctrl_d.erase  = regWdata[nvs_pkg::BIT_ERASE];
      end
      ctrl_d.err    = regWdata[nvs_pkg::BIT_ERR];
      ctrl_d.permit = regWdata[nvs_pkg::BIT_PERM];
      if (regWdata[nvs_pkg::BIT_RD] && !regWdata[nvs_pkg::BIT_MEM] &&
          state_q == ST_IDLE)
      begin
        ctrl_d.rdStart = 1'b1;
        rdStb_d        = 1'b1;
      end
    end
    if (rdStb_q)
      ctrl_d.rdStart = rdStb_d;

    case (state_q)
      ST_IDLE:
      begin
        if (launch)
        begin
          ctrl_d.wrStart = 1'b1;
          if (regWdata[nvs_pkg::BIT_CFG])
            op_d.target = nvs_pkg::TGT_CONFIG;
          else if (regWdata[nvs_pkg::BIT_MEM])
            op_d.target = nvs_pkg::TGT_FLASH;
          else
            op_d.target = nvs_pkg::TGT_DATA;
          op_d.erase = regWdata[nvs_pkg::BIT_ERASE];
          op_d.valid = 1'b1;
          op_d.addr  = table_pointer_q;
          opStb_d    = 1'b1;
          count_d    = 13'(WriteCycles - 1);
          busy_d     = 1'b1;
          stall_d    = regWdata[nvs_pkg::BIT_MEM] ||
                       regWdata[nvs_pkg::BIT_CFG];
          state_d    = ST_BUSY;
        end
      end
      ST_BUSY:
      begin
        if (abortReset)
        begin
          ctrl_d.err     = 1'b1;
          ctrl_d.wrStart = 1'b0;
          ctrl_d.erase   = 1'b0;
          ctrl_d.permit  = 1'b0;
          op_d.valid     = 1'b0;
          stall_d        = 1'b0;
          busy_d         = 1'b0;
          state_d        = ST_IDLE;
        end
        else if (count_q == 13'h0)
          state_d = ST_DONE;
        else
          count_d = count_q - 13'h1;
      end
      ST_DONE:
      begin
        ctrl_d.wrStart = 1'b0;
        ctrl_d.erase   = op_q.erase ? 1'b0 : ctrl_q.erase;
        ctrl_d.err     = 1'b0;
        op_d.valid     = 1'b0;
        stall_d        = 1'b0;
        busy_d         = 1'b0;
        state_d        = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  // ==========================================================
  // Table pointer and latch
  // ==========================================================
  always_comb
  begin
    table_pointer_d = table_pointer_q;
    latch_d  = latch_q;
    if (regWrite && regAddr == nvs_pkg::ADDR_TBLPTR0)
      table_pointer_d[7:0] = regWdata;
    if (regWrite && regAddr == nvs_pkg::ADDR_TBLPTR1)
      table_pointer_d[15:8] = regWdata;
    if (regWrite && regAddr == nvs_pkg::ADDR_TBLPTR2)
      table_pointer_d[21:16] = regWdata[5:0];
    if (regWrite && regAddr == nvs_pkg::ADDR_LATCH)
      latch_d = regWdata;
    if (tblWrite)
      table_pointer_d = table_pointer_q + 22'h1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      table_pointer_q <= 22'h0;
      latch_q  <= 8'h00;
    end
    else
    begin
      table_pointer_q <= table_pointer_d;
      latch_q  <= latch_d;
    end
  end

  // ==========================================================
  // Nonvolatile read capture
  // ==========================================================
  always_comb
  begin
    rdPend_d = rdStb_q;
    rdBuf_d  = rdBuf_q;
    if (rdPend_q)
      rdBuf_d = nvmReadData;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdPend_q <= 1'b0;
      rdBuf_q  <= 8'h00;
    end
    else
    begin
      rdPend_q <= rdPend_d;
      rdBuf_q  <= rdBuf_d;
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  always_comb
  begin
    rdata_d = 8'h00;
    if (regRead)
    begin
      case (regAddr)
        nvs_pkg::ADDR_CONTROL:
          rdata_d = {ctrl_q.memSel, ctrl_q.cfgSel, 1'b0, ctrl_q.erase,
                     ctrl_q.err, ctrl_q.permit, ctrl_q.wrStart,
                     ctrl_q.rdStart};
        nvs_pkg::ADDR_TBLPTR0: rdata_d = table_pointer_q[7:0];
        nvs_pkg::ADDR_TBLPTR1: rdata_d = table_pointer_q[15:8];
        nvs_pkg::ADDR_TBLPTR2: rdata_d = {2'h0, table_pointer_q[21:16]};
        nvs_pkg::ADDR_LATCH:   rdata_d = latch_q;
        nvs_pkg::ADDR_RDDATA:  rdata_d = rdBuf_q;
        default:               rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  // ==========================================================
  // Sequencer registers
  // ==========================================================
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q  <= ST_IDLE;
      ctrl_q   <= '0;
      count_q  <= 13'h0;
      op_q     <= '0;
      opStb_q  <= 1'b0;
      rdStb_q  <= 1'b0;
      stall_q  <= 1'b0;
      busy_q   <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      ctrl_q   <= ctrl_d;
      count_q  <= count_d;
      op_q     <= op_d;
      opStb_q  <= opStb_d;
      rdStb_q  <= rdStb_d;
      stall_q  <= stall_d;
      busy_q   <= busy_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign regRdata    = rdata_q;
  assign nvmReadStb  = rdStb_q;
  assign nvmOpStb    = opStb_q;
  assign nvmOp       = op_q;
  assign nvmProgData = holdData;
  assign coreStall   = stall_q;
  assign busy        = busy_q;

endmodule : nvs_sequencer
`default_nettype wire

// ==== nvs_pkg.sv ====
`default_nettype none
package nvs_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_UNLOCK  = 4'h1;
  localparam logic [3:0] ADDR_TBLPTR0 = 4'h2;
  localparam logic [3:0] ADDR_TBLPTR1 = 4'h3;
  localparam logic [3:0] ADDR_TBLPTR2 = 4'h4;
  localparam logic [3:0] ADDR_LATCH   = 4'h5;
  localparam logic [3:0] ADDR_TBLWR   = 4'h6;
  localparam logic [3:0] ADDR_RDDATA  = 4'h7;

  // ==========================================================
  // Control fields
  // ==========================================================
  localparam int BIT_MEM   = 7;
  localparam int BIT_CFG   = 6;
  localparam int BIT_ERASE = 4;
  localparam int BIT_ERR   = 3;
  localparam int BIT_PERM  = 2;
  localparam int BIT_WR    = 1;
  localparam int BIT_RD    = 0;

  localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'haa;

  localparam int HOLD_BYTES = 8;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_PERIOD_NS   = 50;
  localparam int WRITE_TIME_US   = 4;
  localparam int WRITE_CYCLES    = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0]
  {
    TGT_DATA   = 2'h0,
    TGT_FLASH  = 2'h1,
    TGT_CONFIG = 2'h2
  } nvs_target_t;

  typedef struct packed
  {
    logic        memSel;
    logic        cfgSel;
    logic        erase;
    logic        err;
    logic        permit;
    logic        wrStart;
    logic        rdStart;
  } nvs_ctrl_t;

  typedef struct packed
  {
    logic        valid;
    logic        erase;
    nvs_target_t target;
    logic [21:0] addr;
  } nvs_op_t;

endpackage : nvs_pkg
`default_nettype wire

// ==== nvs_holding_reg.sv ====
`timescale 1ns/100ps
`default_nettype none
module nvs_holding_reg
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        load,
  input  wire logic [2:0]  index,
  input  wire logic [7:0]  dataIn,
  output logic      [63:0] holdData
);

  logic [7:0] bytes_q [nvs_pkg::HOLD_BYTES];
  logic [7:0] bytes_d [nvs_pkg::HOLD_BYTES];

  // ==========================================================
  // Byte lanes
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < nvs_pkg::HOLD_BYTES; g++)
    begin : gLane
      always_comb
      begin
        bytes_d[g] = bytes_q[g];
        if (load && (index == 3'(g)))
          bytes_d[g] = dataIn;
      end
      always_ff @(posedge clk)
      begin
        if (srst)
          bytes_q[g] <= 8'hff;
        else
          bytes_q[g] <= bytes_d[g];
      end
      assign holdData[g*8 +: 8] = bytes_q[g];
    end
  endgenerate

endmodule : nvs_holding_reg
`default_nettype wire

// ==== nvs_unlock.sv ====
`timescale 1ns/100ps
`default_nettype none
module nvs_unlock
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       anyWrite,
  input  wire logic       unlockWrite,
  input  wire logic [7:0] wdata,
  output logic            armed
);

  logic [1:0] stage_q;
  logic [1:0] stage_d;

  // ==========================================================
  // Sequence tracker
  // ==========================================================
  always_comb
  begin
    stage_d = stage_q;
    if (unlockWrite && wdata == nvs_pkg::UNLOCK_FIRST)
      stage_d = 2'h1;
    else if (unlockWrite && stage_q == 2'h1 &&
             wdata == nvs_pkg::UNLOCK_SECOND)
      stage_d = 2'h2;
    else if (anyWrite)
      stage_d = 2'h0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      stage_q <= 2'h0;
    else
      stage_q <= stage_d;
  end

  assign armed = (stage_q == 2'h2);

endmodule : nvs_unlock
`default_nettype wire

// ==== nvs_sequencer_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module nvs_sequencer_props
#(
  parameter int WriteCycles = nvs_pkg::WRITE_CYCLES
)
(
  input wire logic             clk,
  input wire logic             srst,
  input wire logic             masterClearReset,
  input wire logic             watchdogTimeout,
  input wire logic [3:0]       regAddr,
  input wire logic [7:0]       regWdata,
  input wire logic             regWrite,
  input wire logic             regRead,
  input wire logic [7:0]       regRdata,
  input wire logic             nvmReadStb,
  input wire logic             nvmOpStb,
  input wire nvs_pkg::nvs_op_t nvmOp,
  input wire logic             coreStall,
  input wire logic             busy
);
  // ==========================================================
  // Helpers
  // ==========================================================
  logic [7:0]           cntQ;
  logic [7:0]           cntD;
  logic                 abort;
  logic                 ctlWr;
  logic                 startWr;
  logic                 ersQ;
  nvs_pkg::nvs_target_t tgtQ;
  assign abort = masterClearReset | watchdogTimeout;
  assign ctlWr = regWrite && regAddr == nvs_pkg::ADDR_CONTROL;
  assign startWr = ctlWr && regWdata[1];
  assign cntD = busy ? cntQ + 8'h01 : 8'h00;
  always_ff @(posedge clk)
  begin
    cntQ <= cntD;
    if (ctlWr)
    begin
      ersQ <= regWdata[4];
      tgtQ <= regWdata[6] ? nvs_pkg::TGT_CONFIG :
              regWdata[7] ? nvs_pkg::TGT_FLASH : nvs_pkg::TGT_DATA;
    end
  end

  // ==========================================================
  // Properties
  // ==========================================================
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_stall;
    busy |-> coreStall == (nvmOp.target != nvs_pkg::TGT_DATA);
  endproperty
  a_stall: assert property (p_stall) else $error("stall mismatch");
  property p_len;
    $fell(busy) && !$past(abort) |-> $past(cntQ) == WriteCycles;
  endproperty
  a_len: assert property (p_len) else $error("cycle length");
  property p_abort;
    busy && abort |=> !busy;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
  property p_rd;
    ctlWr && regWdata[0] && !regWdata[7] && !busy
      |=> nvmReadStb ##1 !nvmReadStb;
  endproperty
  a_rd: assert property (p_rd) else $error("read pulse");
  property p_rdno;
    ctlWr && regWdata[7] |=> !nvmReadStb;
  endproperty
  a_rdno: assert property (p_rdno) else $error("read not refused");
  property p_bit5;
    regRead && regAddr == nvs_pkg::ADDR_CONTROL |=> !regRdata[5];
  endproperty
  a_bit5: assert property (p_bit5) else $error("bit five set");
  property p_cause;
    nvmOpStb |-> $past(startWr) && busy && nvmOp.valid;
  endproperty
  a_cause: assert property (p_cause) else $error("bad launch");
  property p_tgt;
    nvmOpStb |-> nvmOp.target == tgtQ && nvmOp.erase == ersQ;
  endproperty
  a_tgt: assert property (p_tgt) else $error("bad target");
  c_launch: cover property (nvmOpStb);
  c_abort: cover property (busy && abort);
  c_read: cover property (nvmReadStb);
endmodule : nvs_sequencer_props

bind nvs_sequencer nvs_sequencer_props #(.WriteCycles(WriteCycles))
  nvs_sequencer_props_i (.clk(clk), .srst(srst),
  .masterClearReset(masterClearReset), .watchdogTimeout(watchdogTimeout),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata(regRdata), .nvmReadStb(nvmReadStb),
  .nvmOpStb(nvmOpStb), .nvmOp(nvmOp), .coreStall(coreStall), .busy(busy));
`default_nettype wire

// ==== nvs_nvm_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module nvs_nvm_model
(
  input  wire logic       clk,
  input  wire logic       nvmReadStb,
  output logic      [7:0] nvmReadData
);
  logic [3:0] rdCnt = 4'h0;
  logic [1:0] holdCnt = 2'h0;
  logic [7:0] junk = 8'h00;
  always @(posedge clk)
  begin
    junk <= junk + 8'h35;
    if (nvmReadStb)
      holdCnt <= 2'h2;
    else if (holdCnt != 2'h0)
      holdCnt <= holdCnt - 2'h1;
    if (holdCnt == 2'h1 && !nvmReadStb)
      rdCnt <= rdCnt + 4'h1;
  end
  assign nvmReadData = (nvmReadStb || holdCnt != 2'h0) ?
                       {4'ha, rdCnt} : junk;
endmodule : nvs_nvm_model
`default_nettype wire

// ==== test_nvs_sequencer.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_nvs_sequencer;
  localparam logic [3:0] Ctl = nvs_pkg::ADDR_CONTROL;
  logic             clk = 1'b0;
  logic             srst = 1'b1;
  logic             masterClearReset = 1'b0;
  logic             watchdogTimeout = 1'b0;
  logic [3:0]       regAddr = 4'h0;
  logic [7:0]       regWdata = 8'h00;
  logic             regWrite = 1'b0;
  logic             regRead = 1'b0;
  logic [7:0]       regRdata;
  logic [7:0]       nvmReadData;
  logic             nvmReadStb;
  logic             nvmOpStb;
  nvs_pkg::nvs_op_t nvmOp;
  logic [63:0]      nvmProgData;
  logic             coreStall;
  logic             busy;
  logic [7:0]       expQ[$];
  logic             rdPend = 1'b0;
  logic [63:0]      hold;
  logic [7:0]       modes[4] = '{8'h04, 8'h94, 8'h8c, 8'h44};
  int               error_cnt = 0;
  int               compares = 0;
  int               cycles = 0;

  always #25 clk = ~clk;
  nvs_sequencer #(.WriteCycles(4)) nvs_sequencer_i (.clk(clk), .srst(srst),
    .masterClearReset(masterClearReset), .watchdogTimeout(watchdogTimeout),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .nvmReadData(nvmReadData),
    .nvmReadStb(nvmReadStb), .nvmOpStb(nvmOpStb), .nvmOp(nvmOp),
    .nvmProgData(nvmProgData), .coreStall(coreStall), .busy(busy));
  nvs_nvm_model nvs_nvm_model_i (.clk(clk), .nvmReadStb(nvmReadStb),
    .nvmReadData(nvmReadData));

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic results;
    $display("Errors %0d, compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    regWrite <= w;
    regRead <= !w;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rd
  task automatic idle(input int n);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic launch(input logic [7:0] m);
    bus(1'b1, Ctl, m);
    bus(1'b1, nvs_pkg::ADDR_UNLOCK, nvs_pkg::UNLOCK_FIRST);
    bus(1'b1, nvs_pkg::ADDR_UNLOCK, nvs_pkg::UNLOCK_SECOND);
    bus(1'b1, Ctl, m | 8'h02);
  endtask : launch
  task automatic waitIdle;
    idle(1);
    for (int i = 0; i < 20; i++)
    begin
      @(posedge clk);
      #1;
      if (busy === 1'b0)
        break;
    end
    @(posedge clk);
  endtask : waitIdle

  // ==========================================================
  // Read monitor and timeout
  // ==========================================================
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (rdPend)
      chk(regRdata, expQ.pop_front());
    rdPend <= regRead;
    if (cycles > 3000)
    begin
      error_cnt++;
      results();
    end
  end

  // ==========================================================
  // Scenarios
  // ==========================================================
  initial
  begin
    void'($urandom(32'he208));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(Ctl, 8'h00);
    rd(4'($urandom_range(15, 8)), 8'h00);
    bus(1'b1, Ctl, 8'h06);
    rd(Ctl, 8'h04);
    for (int i = 2; i < 5; i++)
      bus(1'b1, 4'(i), 8'h00);
    for (int g = 0; g < 8; g++)
    begin
      for (int i = 0; i < 8; i++)
      begin
        hold[8*i +: 8] = 8'($urandom);
        bus(1'b1, nvs_pkg::ADDR_LATCH, hold[8*i +: 8]);
        bus(1'b1, nvs_pkg::ADDR_TBLWR, 8'h00);
      end
      idle(1);
      chk(nvmProgData, hold);
      launch(8'h84);
      waitIdle();
      rd(Ctl, 8'h84);
    end
    rd(nvs_pkg::ADDR_TBLPTR0, 8'h40);
    rd(nvs_pkg::ADDR_TBLPTR1, 8'h00);
    rd(nvs_pkg::ADDR_LATCH, hold[63:56]);
    foreach (modes[i])
    begin
      launch(modes[i]);
      rd(Ctl, modes[i] | 8'h02);
      bus(1'b1, Ctl, modes[i]);
      rd(Ctl, modes[i] | 8'h02);
      waitIdle();
      rd(Ctl, modes[i] & 8'he7);
    end
    launch(8'h80);
    rd(Ctl, 8'h80);
    for (int k = 0; k < 2; k++)
    begin
      launch(8'h84);
      idle(2);
      masterClearReset <= (k == 0);
      watchdogTimeout <= (k == 1);
      @(posedge clk);
      masterClearReset <= 1'b0;
      watchdogTimeout <= 1'b0;
      rd(Ctl, 8'h88);
    end
    bus(1'b1, Ctl, 8'h81);
    rd(Ctl, 8'h80);
    bus(1'b1, Ctl, 8'h01);
    rd(Ctl, 8'h01);
    rd(Ctl, 8'h00);
    idle(1);
    rd(nvs_pkg::ADDR_RDDATA, 8'ha0);
    idle(2);
    results();
  end
endmodule : test_nvs_sequencer
`default_nettype wire
